//--- design/dirc_pkg.sv
// Purpose: Shared constants for the drive interlock and ramp control.
// Assumes: 20 MHz core clock; ramp times are set in 0.1 s units.
// Notes:   Every count used by more than one file is named here once.
package dirc_pkg;

  // ****************************************************************
  // Clock and control tick
  // ****************************************************************
  localparam int CLK_HZ   = 20_000_000;  // Core clock rate in Hz.
  localparam int TICK_US  = 100;         // Control tick period in us.
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [10:0] TICK_LAST = 11'(TICK_CYC - 1);

  // ****************************************************************
  // Ramp settings
  // ****************************************************************
  localparam int TIME_UNIT_MS  = 100;    // One setting step, 0.1 s.
  localparam int TICK_PER_UNIT = TIME_UNIT_MS * 1000 / TICK_US;
  localparam logic [6:0]  RAMP_MIN    = 7'h02;  // 0.2 s.
  localparam logic [6:0]  RAMP_MAX    = 7'h50;  // 8.0 s.
  localparam logic [6:0]  KEYOFF_MAX  = 7'h28;  // 4.0 s.
  localparam logic [7:0]  FULL_SCALE  = 8'hFF;  // Full-scale command.
  localparam logic [7:0]  HIGH_SPEED  = 8'h80;  // High/low speed split.
  localparam logic [7:0]  POT_MID     = 8'h80;  // Pot max/min split.

  // ****************************************************************
  // Lamp, horn and charge tracking
  // ****************************************************************
  localparam int HORN_HALF_MS = 500;     // Half period of 1 Hz.
  localparam int FLASH_ON_MS  = 250;     // One flash on or off time.
  localparam int FLASH_GAP_MS = 1000;    // Pause between flash groups.
  localparam logic [13:0] HORN_HALF =
    14'(HORN_HALF_MS * 1000 / TICK_US);
  localparam logic [13:0] FLASH_ON  =
    14'(FLASH_ON_MS * 1000 / TICK_US);
  localparam logic [13:0] FLASH_GAP =
    14'(FLASH_GAP_MS * 1000 / TICK_US);
  localparam logic [6:0]  CHARGE_FULL_PCT = 7'h64;  // 100 percent.

  // Lamp sequencer states.
  typedef enum logic [1:0] {
    LAMP_STEADY,
    LAMP_ON,
    LAMP_OFF,
    LAMP_GAP
  } dirc_lamp_t;

  // Limits a programmed ramp time to its legal range.
  function automatic logic [6:0] dirc_clamp(input logic [6:0] t,
                                            input logic [6:0] hi);
    if (t < RAMP_MIN) begin
      return RAMP_MIN;
    end
    if (t > hi) begin
      return hi;
    end
    return t;
  endfunction : dirc_clamp

endpackage : dirc_pkg

//--- design/dirc_ramp_if.sv
// Purpose: Carries the ramp request and result between the modules.
// Assumes: All signals are in the core clock domain.
// Notes:   The control side drives target and time, the ramp the command.
`timescale 1ns/10ps
interface dirc_ramp_if;
  logic       tick;       // One-cycle control tick.
  logic [7:0] target;     // Requested speed command.
  logic [6:0] ramp_time;  // Full-scale time in 0.1 s units.
  logic [7:0] cmd;        // Present speed command.

  modport ctrl (output tick, output target, output ramp_time,
                input cmd);
  modport ramp (input tick, input target, input ramp_time,
                output cmd);
endinterface : dirc_ramp_if

//--- design/dirc_ramp.sv
// Purpose: Steps the speed command linearly toward its target.
// Assumes: The ramp time is already clamped to 0.2 s or more.
// Notes:   At most one step per tick, since a tick is far shorter.
`timescale 1ns/10ps
module dirc_ramp
  import dirc_pkg::*;
(
  input  wire logic CLK_I,
  input  wire logic RST_B_I,
  dirc_ramp_if.ramp RAMP
);

  // ****************************************************************
  // Step accumulator
  // ****************************************************************
  logic [16:0] acc_ff;     // Fraction of a step gathered so far.
  logic [7:0]  cmd_ff;     // Speed command register.
  logic [16:0] limit;      // Ticks times full scale for one step.
  logic [16:0] nxt_acc;    // Accumulator plus one tick's share.

  // The full-scale change takes ramp_time; each tick earns 255 parts.
  always_comb begin
    limit   = 17'(RAMP.ramp_time * TICK_PER_UNIT);
    nxt_acc = acc_ff + {9'h000, FULL_SCALE};
  end

  // Moves the command one unit whenever a whole step is earned.
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc_ff <= 17'h00000;
      cmd_ff <= 8'h00;
    end else if (RAMP.tick) begin
      if (cmd_ff == RAMP.target) begin
        acc_ff <= 17'h00000;
      end else if (nxt_acc >= limit) begin
        acc_ff <= nxt_acc - limit;
        if (cmd_ff < RAMP.target) begin
          cmd_ff <= cmd_ff + 8'h01;
        end else begin
          cmd_ff <= cmd_ff - 8'h01;
        end
      end else begin
        acc_ff <= nxt_acc;
      end
    end
  end

  assign RAMP.cmd = cmd_ff;

endmodule : dirc_ramp

//--- design/dirc_top.sv
// Purpose: Drive interlock, speed ramp, lamp, horn and charge tracking.
// Assumes: All inputs are synchronous to CORE_CLK_I; settings are static.
// Notes:   Ramp times are in 0.1 s units; the command is 8-bit full scale.
`timescale 1ns/10ps
module dirc_top
  import dirc_pkg::*;
(
  input  wire logic       CORE_CLK_I,         // Core clock, 20 MHz.
  input  wire logic       RST_B_I,            // Async reset, active low.
  input  wire logic       KEY_ON_I,           // Keyswitch on.
  input  wire logic       ESTOP_I,            // Emergency stop pressed.
  input  wire logic       CHARGER_INH_I,      // Charger inhibit active.
  input  wire logic       SPEED_INH_I,        // Speed inhibit active.
  input  wire logic [7:0] INH_MAX_SPEED_I,    // Inhibit speed cap.
  input  wire logic       NEUTRAL_EN_I,       // Neutral input in use.
  input  wire logic       NEUTRAL_I,          // Neutral input level.
  input  wire logic       REVERSE_SW_I,       // Reverse switch.
  input  wire logic       THR_SINGLE_I,       // Single-ended/unipolar.
  input  wire logic       THR_REV_I,          // Two-sided throttle sign.
  input  wire logic [7:0] THROTTLE_I,         // Throttle request.
  input  wire logic [7:0] SPEED_POT_I,        // Speed limit pot.
  input  wire logic       POT_FAULT_I,        // Throttle pot fault.
  input  wire logic       MAJOR_FAULT_I,      // Major fault.
  input  wire logic       AUTOCAL_I,          // Autocalibration running.
  input  wire logic [3:0] FLASH_CODE_I,       // Fault code, 0 for none.
  input  wire logic       HORN_BRAKE_LIGHT_I, // Horn pin as brake light.
  input  wire logic       LIFT_LOCK_EN_I,     // Horn pin as pump relay.
  input  wire logic       EXT_LOCK_EN_I,      // External lockout in use.
  input  wire logic       EXT_LOCK_I,         // External lockout input.
  input  wire logic [6:0] ACC_FWD_MAX_I,      // Fwd accel, pot max.
  input  wire logic [6:0] ACC_FWD_MIN_I,      // Fwd accel, pot min.
  input  wire logic [6:0] DEC_FWD_HI_I,       // Fwd decel, high speed.
  input  wire logic [6:0] DEC_FWD_LO_I,       // Fwd decel, low speed.
  input  wire logic [6:0] ACC_REV_MAX_I,      // Rev accel, pot max.
  input  wire logic [6:0] ACC_REV_MIN_I,      // Rev accel, pot min.
  input  wire logic [6:0] DEC_REV_HI_I,       // Rev decel, high speed.
  input  wire logic [6:0] DEC_REV_LO_I,       // Rev decel, low speed.
  input  wire logic [6:0] KEY_OFF_DEC_I,      // Key-off decel time.
  input  wire logic       CHARGE_FULL_I,      // Pulse: charge complete.
  input  wire logic       DISCHARGE_STEP_I,   // Pulse: one percent used.
  output logic      [7:0] SPEED_CMD_O,        // Ramped speed command.
  output logic            DIR_REV_O,          // Driving in reverse.
  output logic            DRIVE_EN_O,         // Drive output on.
  output logic            HOLDING_BRAKE_O,    // Brake coil energised.
  output logic            STATUS_LAMP_O,      // Status lamp.
  output logic            HORN_O,             // Horn/light/relay pin.
  output logic            LIFT_LOCK_O,        // Lift lockout output.
  output logic            POWER_HOLD_O,       // Keep logic power on.
  output logic      [6:0] CHARGE_STATE_O,     // State of charge, percent.
  output logic            CHARGE_STATE_VALID_O // Tracker is running.
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dirc_ramp_if ramp_bus ();       // Link to the ramp stepper.

  logic [10:0] tick_cnt_ff;       // Core cycles within a tick.
  logic        tick_ff;           // One-cycle control tick.
  logic [13:0] horn_cnt_ff;       // Ticks within a horn half period.
  logic        horn_phase_ff;     // Horn on/off phase, 1 Hz.
  dirc_lamp_t  lamp_st_ff;        // Lamp sequencer state.
  logic [13:0] lamp_cnt_ff;       // Ticks left in this lamp phase.
  logic [3:0]  flash_left_ff;     // Flashes left in this group.
  logic        dir_rev_ff;        // Latched driving direction.
  logic        drive_en_ff;       // Drive output register.
  logic        brake_rel_ff;      // Brake release request.
  logic        horn_ff;           // Horn pin register.
  logic        lift_lock_ff;      // Lift lockout register.
  logic        power_ff;          // Power hold register.
  logic        shutdown_ff;       // Charge reset done, power removed.
  logic        armed_ff;          // Full charge cycle observed.
  logic [6:0]  pct_ff;            // State of charge in percent.
  logic        want_rev;          // Requested direction is reverse.
  logic        stop_req;          // Key off or fault stop request.
  logic        hard_off;          // Stop, charger or neutral cut.
  logic        blocked;           // Inhibit with zero cap.
  logic [7:0]  nxt_target;        // Target for the ramp.
  logic [6:0]  nxt_time;          // Ramp time for this step.
  logic        powered;           // Controller logic is powered.
  logic        full_event;        // Charge completion with charger.

  // ****************************************************************
  // Control tick divider
  // ****************************************************************
  // Makes a one-cycle tick every 100 us for all slower timing.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tick_cnt_ff <= 11'h000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= 11'h000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 11'h001;
      tick_ff     <= 1'b0;
    end
  end

  // ****************************************************************
  // Direction and interlocks
  // ****************************************************************
  // Works out direction, stop requests and the hard cut conditions.
  always_comb begin
    // Two-sided throttles give direction from their own sign.
    want_rev = THR_SINGLE_I ? REVERSE_SW_I : THR_REV_I;
    stop_req = !KEY_ON_I || MAJOR_FAULT_I || POT_FAULT_I;
    // Stop and charger beat every other request.
    hard_off = ESTOP_I || CHARGER_INH_I ||
               (NEUTRAL_EN_I && !NEUTRAL_I);
    blocked  = SPEED_INH_I && (INH_MAX_SPEED_I == 8'h00);
  end

  // Direction may change only once the command is back at zero.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dir_rev_ff <= 1'b0;
    end else if (ramp_bus.cmd == 8'h00) begin
      dir_rev_ff <= want_rev;
    end
  end

  // ****************************************************************
  // Speed target and ramp time selection
  // ****************************************************************
  // Picks the target, then the ramp time for the way it moves.
  always_comb begin
    nxt_target = THROTTLE_I;
    if (SPEED_INH_I && (THROTTLE_I > INH_MAX_SPEED_I)) begin
      nxt_target = INH_MAX_SPEED_I;
    end
    // Reversal first brings the command down to zero.
    if (hard_off || blocked || stop_req ||
        (want_rev != dir_rev_ff)) begin
      nxt_target = 8'h00;
    end
    if (stop_req) begin
      // Key off and faults stop at the key-off rate.
      nxt_time = dirc_clamp(KEY_OFF_DEC_I, KEYOFF_MAX);
    end else if (nxt_target > ramp_bus.cmd) begin
      if (dir_rev_ff) begin
        nxt_time = (SPEED_POT_I >= POT_MID) ?
                   dirc_clamp(ACC_REV_MAX_I, RAMP_MAX) :
                   dirc_clamp(ACC_REV_MIN_I, RAMP_MAX);
      end else begin
        nxt_time = (SPEED_POT_I >= POT_MID) ?
                   dirc_clamp(ACC_FWD_MAX_I, RAMP_MAX) :
                   dirc_clamp(ACC_FWD_MIN_I, RAMP_MAX);
      end
    end else if (dir_rev_ff) begin
      nxt_time = (ramp_bus.cmd >= HIGH_SPEED) ?
                 dirc_clamp(DEC_REV_HI_I, RAMP_MAX) :
                 dirc_clamp(DEC_REV_LO_I, RAMP_MAX);
    end else begin
      nxt_time = (ramp_bus.cmd >= HIGH_SPEED) ?
                 dirc_clamp(DEC_FWD_HI_I, RAMP_MAX) :
                 dirc_clamp(DEC_FWD_LO_I, RAMP_MAX);
    end
  end

  assign ramp_bus.tick      = tick_ff;
  assign ramp_bus.target    = nxt_target;
  assign ramp_bus.ramp_time = nxt_time;

  // Steps the speed command toward the target.
  dirc_ramp u_ramp (
    .CLK_I   (CORE_CLK_I),
    .RST_B_I (RST_B_I),
    .RAMP    (ramp_bus.ramp)
  );

  // ****************************************************************
  // Drive and brake outputs
  // ****************************************************************
  // Drive stays on while there is motion to make and nothing cuts it.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      drive_en_ff  <= 1'b0;
      brake_rel_ff <= 1'b0;
    end else begin
      drive_en_ff  <= !hard_off && !blocked &&
                      (ramp_bus.cmd != 8'h00 || nxt_target != 8'h00);
      brake_rel_ff <= !ESTOP_I && !CHARGER_INH_I &&
                      (ramp_bus.cmd != 8'h00 || nxt_target != 8'h00);
    end
  end

  // The stop input also gates the coil directly so it drops at once.
  assign HOLDING_BRAKE_O = brake_rel_ff && !ESTOP_I;
  assign DRIVE_EN_O      = drive_en_ff;
  assign SPEED_CMD_O     = ramp_bus.cmd;
  assign DIR_REV_O       = dir_rev_ff;

  // ****************************************************************
  // Charge tracking and power hold
  // ****************************************************************
  assign full_event = CHARGE_FULL_I && CHARGER_INH_I;

  // Tracks state of charge once a full charge has been seen.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      armed_ff <= 1'b0;
      pct_ff   <= 7'h00;
    end else if (full_event) begin
      armed_ff <= 1'b1;
      pct_ff   <= CHARGE_FULL_PCT;
    end else if (armed_ff && DISCHARGE_STEP_I &&
                 !CHARGER_INH_I && pct_ff != 7'h00) begin
      pct_ff <= pct_ff - 7'h01;
    end
  end

  // Charger wakes the unit; after the reset to full, power goes off.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      shutdown_ff <= 1'b0;
      power_ff    <= 1'b0;
    end else begin
      if (full_event && !KEY_ON_I) begin
        shutdown_ff <= 1'b1;
      end else if (KEY_ON_I || !CHARGER_INH_I) begin
        shutdown_ff <= 1'b0;
      end
      power_ff <= KEY_ON_I ||
                  (CHARGER_INH_I && !shutdown_ff &&
                   !(full_event && !KEY_ON_I));
    end
  end

  assign powered              = power_ff;
  assign POWER_HOLD_O         = power_ff;
  assign CHARGE_STATE_VALID_O = armed_ff;
  assign CHARGE_STATE_O       = armed_ff ? pct_ff : 7'h00;

  // ****************************************************************
  // Status lamp
  // ****************************************************************
  // Steady while powered; a fault code gives groups of N flashes.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      lamp_st_ff    <= LAMP_STEADY;
      lamp_cnt_ff   <= 14'h0000;
      flash_left_ff <= 4'h0;
    end else if (!powered || FLASH_CODE_I == 4'h0) begin
      lamp_st_ff    <= LAMP_STEADY;
      lamp_cnt_ff   <= 14'h0000;
      flash_left_ff <= 4'h0;
    end else if (tick_ff) begin
      case (lamp_st_ff)
        LAMP_STEADY: begin
          // Starts a group with a pause to mark its start.
          lamp_st_ff    <= LAMP_GAP;
          lamp_cnt_ff   <= FLASH_GAP;
          flash_left_ff <= FLASH_CODE_I;
        end
        LAMP_GAP: begin
          if (lamp_cnt_ff == 14'h0000) begin
            lamp_st_ff    <= LAMP_ON;
            lamp_cnt_ff   <= FLASH_ON;
            flash_left_ff <= FLASH_CODE_I;
          end else begin
            lamp_cnt_ff <= lamp_cnt_ff - 14'h0001;
          end
        end
        LAMP_ON: begin
          if (lamp_cnt_ff == 14'h0000) begin
            lamp_st_ff    <= LAMP_OFF;
            lamp_cnt_ff   <= FLASH_ON;
            flash_left_ff <= flash_left_ff - 4'h1;
          end else begin
            lamp_cnt_ff <= lamp_cnt_ff - 14'h0001;
          end
        end
        LAMP_OFF: begin
          if (lamp_cnt_ff != 14'h0000) begin
            lamp_cnt_ff <= lamp_cnt_ff - 14'h0001;
          end else if (flash_left_ff == 4'h0) begin
            lamp_st_ff  <= LAMP_GAP;
            lamp_cnt_ff <= FLASH_GAP;
          end else begin
            lamp_st_ff  <= LAMP_ON;
            lamp_cnt_ff <= FLASH_ON;
          end
        end
        default: begin
          lamp_st_ff <= LAMP_STEADY;
        end
      endcase
    end
  end

  // Lamp is dark only when unpowered or in an off or gap phase of a code.
  assign STATUS_LAMP_O = powered &&
                         (lamp_st_ff == LAMP_STEADY ||
                          lamp_st_ff == LAMP_ON);

  // ****************************************************************
  // Horn pin and lift lockout
  // ****************************************************************
  // Toggles the horn phase every half second for a 1 Hz pulse.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      horn_cnt_ff   <= 14'h0000;
      horn_phase_ff <= 1'b0;
    end else if (tick_ff) begin
      if (horn_cnt_ff == HORN_HALF - 14'h0001) begin
        horn_cnt_ff   <= 14'h0000;
        horn_phase_ff <= !horn_phase_ff;
      end else begin
        horn_cnt_ff <= horn_cnt_ff + 14'h0001;
      end
    end
  end

  // Chooses relay, brake light or horn for the shared pin.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      horn_ff      <= 1'b0;
      lift_lock_ff <= 1'b0;
    end else begin
      lift_lock_ff <= EXT_LOCK_EN_I && !EXT_LOCK_I;
      if (LIFT_LOCK_EN_I) begin
        // Pump relay runs unless lockout is active; horn is silent.
        horn_ff <= powered &&
                   !(EXT_LOCK_EN_I && !EXT_LOCK_I);
      end else if (HORN_BRAKE_LIGHT_I) begin
        // Light while the brake holds or the command falls.
        horn_ff <= powered &&
                   (!brake_rel_ff || nxt_target < ramp_bus.cmd);
      end else begin
        horn_ff <= powered && horn_phase_ff &&
                   (dir_rev_ff || want_rev || AUTOCAL_I);
      end
    end
  end

  assign HORN_O      = horn_ff;
  assign LIFT_LOCK_O = lift_lock_ff;

endmodule : dirc_top

//--- sim/dirc_coil.sv
// Purpose: Brake coil partner model for the drive interlock bench.
// Assumes: Spring brake engages whenever the coil is not energised.
// Notes:   No delay; the brake follows the coil at once.
`timescale 1ns/10ps
module dirc_coil (
  input  wire logic coil_energised_i, // Coil drive from the controller.
  output logic      brake_engaged_o   // Brake clamps the motor shaft.
);
  // The spring sets the brake whenever the coil is dropped.
  assign brake_engaged_o = !coil_energised_i;
endmodule : dirc_coil

//--- sim/dirc_top_props.sv
// Purpose: Port assertions for the drive interlock and ramp control.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Bound to every dirc_top instance below.
`timescale 1ns/10ps
module dirc_top_props (
  input wire logic       CORE_CLK_I,
  input wire logic       RST_B_I,
  input wire logic       KEY_ON_I,
  input wire logic       ESTOP_I,
  input wire logic       CHARGER_INH_I,
  input wire logic       SPEED_INH_I,
  input wire logic [7:0] INH_MAX_SPEED_I,
  input wire logic       NEUTRAL_EN_I,
  input wire logic       NEUTRAL_I,
  input wire logic       REVERSE_SW_I,
  input wire logic       THR_SINGLE_I,
  input wire logic       CHARGE_FULL_I,
  input wire logic       LIFT_LOCK_EN_I,
  input wire logic       EXT_LOCK_EN_I,
  input wire logic       EXT_LOCK_I,
  input wire logic [7:0] SPEED_CMD_O,
  input wire logic       DIR_REV_O,
  input wire logic       DRIVE_EN_O,
  input wire logic       HOLDING_BRAKE_O,
  input wire logic       HORN_O,
  input wire logic       LIFT_LOCK_O,
  input wire logic       POWER_HOLD_O,
  input wire logic [6:0] CHARGE_STATE_O,
  input wire logic       CHARGE_STATE_VALID_O
);
  // All checks run on the core clock and sleep during reset.
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  AST_ESTOP: assert property (ESTOP_I |->
    !HOLDING_BRAKE_O ##1 !DRIVE_EN_O)
    else $error("brake or drive kept on in stop");
  AST_CHARGER: assert property (CHARGER_INH_I |=>
    !DRIVE_EN_O && !HOLDING_BRAKE_O)
    else $error("drive or coil on while charging");
  AST_TRACK_IDLE: assert property (!CHARGE_STATE_VALID_O |->
    CHARGE_STATE_O == 7'h00)
    else $error("charge shown before first full charge");
  AST_WAKE: assert property ($rose(CHARGER_INH_I) && !KEY_ON_I |=>
    POWER_HOLD_O)
    else $error("charger did not wake the unit");
  AST_DONE: assert property (CHARGER_INH_I && CHARGE_FULL_I &&
    !KEY_ON_I |=> !POWER_HOLD_O && CHARGE_STATE_VALID_O &&
    CHARGE_STATE_O == 7'h64)
    else $error("no reset to full and power off");
  AST_NEUTRAL: assert property (NEUTRAL_EN_I && !NEUTRAL_I |=>
    !DRIVE_EN_O)
    else $error("drive on with neutral low");
  AST_ZERO_CAP: assert property (SPEED_INH_I &&
    INH_MAX_SPEED_I == 8'h00 |=> !DRIVE_EN_O)
    else $error("drive on with zero inhibit cap");
  AST_CAP: assert property (SPEED_INH_I && $past(SPEED_INH_I) &&
    $stable(INH_MAX_SPEED_I) && $past(SPEED_CMD_O) <= INH_MAX_SPEED_I
    |-> SPEED_CMD_O <= INH_MAX_SPEED_I)
    else $error("command above inhibit cap");
  AST_STEP: assert property (SPEED_CMD_O == $past(SPEED_CMD_O) ||
    SPEED_CMD_O - $past(SPEED_CMD_O) == 8'h01 ||
    $past(SPEED_CMD_O) - SPEED_CMD_O == 8'h01)
    else $error("command jumped more than one step");
  AST_SPACE: assert property ($changed(SPEED_CMD_O) |=>
    $stable(SPEED_CMD_O) [*8])
    else $error("command stepped twice within a tick");
  AST_EXT_LOCK: assert property (KEY_ON_I && EXT_LOCK_EN_I &&
    !EXT_LOCK_I |=> LIFT_LOCK_O)
    else $error("lockout output idle with input low");
  AST_RELAY: assert property (POWER_HOLD_O && LIFT_LOCK_EN_I &&
    EXT_LOCK_I |=> HORN_O)
    else $error("pump relay off");
  AST_DIR: assert property ((THR_SINGLE_I && REVERSE_SW_I &&
    SPEED_CMD_O == 8'h00) [*2] |=> DIR_REV_O)
    else $error("reverse switch ignored");
endmodule : dirc_top_props
bind dirc_top dirc_top_props u_dirc_top_props (.*);

//--- sim/dirc_top_bench.sv
// Purpose: Self-checking bench for the drive interlock and ramp control.
// Assumes: 20 MHz clock; inputs change by non-blocking writes at edges.
// Notes:   Ramp is checked after about 35 control ticks.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; \
  if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module dirc_top_bench;
  logic CORE_CLK_I, RST_B_I, KEY_ON_I, ESTOP_I, CHARGER_INH_I, SPEED_INH_I;
  logic NEUTRAL_EN_I, NEUTRAL_I, REVERSE_SW_I, THR_SINGLE_I, THR_REV_I;
  logic POT_FAULT_I, MAJOR_FAULT_I, AUTOCAL_I, HORN_BRAKE_LIGHT_I;
  logic LIFT_LOCK_EN_I, EXT_LOCK_EN_I, EXT_LOCK_I, CHARGE_FULL_I;
  logic DISCHARGE_STEP_I, DIR_REV_O, DRIVE_EN_O, HOLDING_BRAKE_O;
  logic STATUS_LAMP_O, HORN_O, LIFT_LOCK_O, POWER_HOLD_O;
  logic CHARGE_STATE_VALID_O, engaged;
  logic [7:0] INH_MAX_SPEED_I, THROTTLE_I, SPEED_POT_I, SPEED_CMD_O;
  logic [6:0] ACC_FWD_MAX_I, ACC_FWD_MIN_I, DEC_FWD_HI_I, DEC_FWD_LO_I;
  logic [6:0] ACC_REV_MAX_I, ACC_REV_MIN_I, DEC_REV_HI_I, DEC_REV_LO_I;
  logic [6:0] KEY_OFF_DEC_I, CHARGE_STATE_O;
  logic [3:0] FLASH_CODE_I;
  int         bad_count, checks_done;

  dirc_top u_dirc_top (.*);
  dirc_coil u_dirc_coil (.coil_energised_i(HOLDING_BRAKE_O),
                         .brake_engaged_o(engaged));

  // Clock of 50 ns period.
  always #25 CORE_CLK_I = ~CORE_CLK_I;

  // Waits n edges, then lets that edge's updates settle.
  task cyc(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #1;
  endtask : cyc

  // Prints the verdict and ends the run.
  task results;
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Cuts a hang short well after the planned run length.
  initial begin
    repeat (90000) @(posedge CORE_CLK_I);
    bad_count++;
    results();
  end

  // Main sequence: interlocks first at standstill, then charge, ramp, stop.
  initial begin
    {CORE_CLK_I, RST_B_I, ESTOP_I, CHARGER_INH_I, THR_REV_I, POT_FAULT_I,
     MAJOR_FAULT_I, AUTOCAL_I, HORN_BRAKE_LIGHT_I, LIFT_LOCK_EN_I,
     EXT_LOCK_I, CHARGE_FULL_I, DISCHARGE_STEP_I, NEUTRAL_I} = '0;
    {KEY_ON_I, SPEED_INH_I, NEUTRAL_EN_I, REVERSE_SW_I, THR_SINGLE_I,
     EXT_LOCK_EN_I} = '1;
    {DEC_FWD_HI_I, DEC_FWD_LO_I, ACC_REV_MAX_I, ACC_REV_MIN_I, DEC_REV_HI_I,
     DEC_REV_LO_I, KEY_OFF_DEC_I} = {7{7'h14}};
    ACC_FWD_MIN_I = 7'h02;
    ACC_FWD_MAX_I = 7'h50;
    {INH_MAX_SPEED_I, SPEED_POT_I, FLASH_CODE_I} = '0;
    THROTTLE_I = 8'h40;
    repeat (6) @(posedge CORE_CLK_I);
    RST_B_I <= 1'b1;
    cyc(3);
    `CHK("dir", 1'b1, DIR_REV_O)
    `CHK("lockout", 1'b1, LIFT_LOCK_O)
    `CHK("drive", 1'b0, DRIVE_EN_O)
    `CHK("cmd", 8'h00, SPEED_CMD_O)
    `CHK("lamp", 1'b1, STATUS_LAMP_O)
    @(posedge CORE_CLK_I)
      {LIFT_LOCK_EN_I, EXT_LOCK_I, HORN_BRAKE_LIGHT_I} <= 3'h7;
    cyc(1);
    `CHK("relay", 1'b1, HORN_O)
    @(posedge CORE_CLK_I) {KEY_ON_I, CHARGER_INH_I, DISCHARGE_STEP_I} <= 3'h3;
    cyc(1);
    `CHK("power", 1'b1, POWER_HOLD_O)
    `CHK("brake", 1'b1, engaged)
    `CHK("drive", 1'b0, DRIVE_EN_O)
    `CHK("valid", 1'b0, CHARGE_STATE_VALID_O)
    `CHK("pct", 7'h00, CHARGE_STATE_O)
    @(posedge CORE_CLK_I) {DISCHARGE_STEP_I, CHARGE_FULL_I} <= 2'h1;
    @(posedge CORE_CLK_I) CHARGE_FULL_I <= 1'b0;
    #1;
    `CHK("valid", 1'b1, CHARGE_STATE_VALID_O)
    `CHK("pct", 7'h64, CHARGE_STATE_O)
    `CHK("power", 1'b0, POWER_HOLD_O)
    // Drive forward under a cap of 3, with a fault code and one discharge.
    @(posedge CORE_CLK_I) begin
      {CHARGER_INH_I, REVERSE_SW_I} <= 2'h0;
      {KEY_ON_I, NEUTRAL_I, DISCHARGE_STEP_I} <= 3'h7;
      INH_MAX_SPEED_I <= 8'h03;
      FLASH_CODE_I <= 4'h2;
    end
    @(posedge CORE_CLK_I) DISCHARGE_STEP_I <= 1'b0;
    cyc(71000);
    `CHK("cmd", 8'h03, SPEED_CMD_O)
    `CHK("drive", 1'b1, DRIVE_EN_O)
    `CHK("pct", 7'h63, CHARGE_STATE_O)
    `CHK("lamp", 1'b0, STATUS_LAMP_O)
    `CHK("brake", 1'b0, engaged)
    // Stop pressed while the horn pin switches to brake light duty.
    @(posedge CORE_CLK_I) {ESTOP_I, LIFT_LOCK_EN_I} <= 2'h2;
    #1;
    `CHK("brake", 1'b1, engaged)
    cyc(1);
    `CHK("drive", 1'b0, DRIVE_EN_O)
    `CHK("light", 1'b1, HORN_O)
    results();
  end
endmodule : dirc_top_bench
